//--- common/emcs_pkg.sv
// Constants and carrier types of the external memory chip-select bus.
// Assumes one bus clock for the whole block and static chip-select setup.
`default_nettype none

package emcs_pkg;
	localparam int NUM_CS = 6;

	// Port width codes of a chip select; the fourth code is read as 32 bits
	localparam logic [1:0] PORT_W32 = 2'h0;
	localparam logic [1:0] PORT_W8 = 2'h1;
	localparam logic [1:0] PORT_W16 = 2'h2;

	// Access size codes: bytes = 1 << code
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	// Data lane masks, last beat indices, wait counts and select patterns
	localparam logic [31:0] LANES_8 = 32'h0000_00ff;
	localparam logic [31:0] LANES_16 = 32'h0000_ffff;
	localparam logic [31:0] LANES_32 = 32'hffff_ffff;
	localparam logic [31:0] DDR_OWN_LANES = 32'h0000_ffff;
	localparam logic [1:0] LAST_BEAT_1 = 2'h0;
	localparam logic [1:0] LAST_BEAT_2 = 2'h1;
	localparam logic [1:0] LAST_BEAT_4 = 2'h3;
	localparam logic [3:0] WAIT_ZERO = 4'h0;
	localparam logic [3:0] WAIT_ONE = 4'h1;
	localparam logic [5:0] CS_ALL_OFF = 6'h3f;
	localparam logic [5:0] CS_ONE_HOT = 6'h01;

	// One chip select: region base and mask cover address bits 31..16
	typedef struct packed {
		logic enable;
		logic [15:0] base;
		logic [15:0] mask;
		logic [1:0] port_w;
		logic [3:0] wait_st;
		logic [3:0] sec_wait;
		logic user_block;
		logic write_block;
		logic split_strobes;
	} emcs_cs_cfg_type;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [1:0] size;
		logic write;
		logic user;
	} emcs_req_type;

	typedef struct packed {
		logic valid;
		logic error;
		logic [31:0] rdata;
	} emcs_resp_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_WAIT1,
		ST_WAIT2,
		ST_DATA
	} emcs_state_type;
endpackage

`default_nettype wire

//--- hdl/emcs_bus.sv
// External asynchronous memory interface with six decoded chip selects.
// Assumes requests and setup come from logic on clk; data pins and the
// DRAM type strap come from outside and are synchronised here.
`default_nettype none

// What this block does
// - In DDR mode data lines 31..16 belong to the SDRAM unit and only lines 15..0 are driven here.
// - In SDR mode all 32 lines are shared and the SDRAM unit gets them only while no access runs.
// - Six chip-select outputs, each enabling one separately programmed region.
// - Each access makes its own timing, inserting the wait states and splitting into port-width beats.
// - A second wait-state count is added after the primary one on reads and writes.
// - An active-low address-valid strobe marks the start of each beat on the bus.
// - A chip select may be set to give separate read-enable and write-enable strobes.
// - Each chip select has its own port width of 8, 16 or 32 bits in SDR mode, and of 8 or 16 bits in DDR mode.
// - A chip select may refuse user-mode accesses and, separately, write accesses.
module emcs_bus (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Setup
	input wire emcs_pkg::emcs_cs_cfg_type [emcs_pkg::NUM_CS-1:0] cs_cfg,
	input wire logic dram_type_select,
	// Internal request and answer
	input wire emcs_pkg::emcs_req_type req,
	output logic req_ready,
	output emcs_pkg::emcs_resp_type resp,
	// SDRAM unit bus sharing
	input wire logic sdram_ctrl_unit_req,
	output logic sdram_ctrl_unit_grant,
	// External bus
	output logic [emcs_pkg::NUM_CS-1:0] cs_n,
	output logic address_valid_n,
	output logic read_en_n,
	output logic write_en_n,
	output logic rd_wr_n,
	output logic [31:0] ext_addr,
	input wire logic [31:0] ext_data_in,
	output logic [31:0] ext_data_out,
	output logic [31:0] ext_data_oe
);
	logic [emcs_pkg::NUM_CS-1:0] hit;
	logic [emcs_pkg::NUM_CS-1:0] blk;

	genvar gi;
	generate
		for (gi = 0; gi < emcs_pkg::NUM_CS; gi++) begin : g_cs
			emcs_cs_match u_match (
				.cfg(cs_cfg[gi]),
				.addr(req.addr),
				.write(req.write),
				.user(req.user),
				.hit(hit[gi]),
				.blocked(blk[gi])
			);
		end
	endgenerate

	// Synchronisers; only the second stage is read
	logic [31:0] din_s1_r, din_s2_r;
	logic ddr_s1_r, ddr_s2_r;
	always_ff @(posedge clk) begin
		din_s1_r <= ext_data_in;
		din_s2_r <= din_s1_r;
		ddr_s1_r <= dram_type_select;
		ddr_s2_r <= ddr_s1_r;
	end

	emcs_pkg::emcs_state_type state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [1:0] beat_r, beat_nxt, last_r, last_nxt, pw_r, pw_nxt, szw_r, szw_nxt;
	logic [5:0] sel_r, sel_nxt;
	logic [31:0] addr_r, addr_nxt, wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic write_r, write_nxt, split_r, split_nxt;
	logic [3:0] wait_r, wait_nxt, sec_r, sec_nxt;
	logic grant_r, grant_nxt, ready_r, ready_nxt;
	emcs_pkg::emcs_resp_type resp_r, resp_nxt;
	logic [5:0] cs_n_r, cs_n_nxt;
	logic avn_r, avn_nxt, ren_r, ren_nxt, wen_r, wen_nxt, rw_r, rw_nxt;
	logic [31:0] eaddr_r, eaddr_nxt, dout_r, dout_nxt, doe_r, doe_nxt;

	// Lanes and bit offset of a beat for an effective port width
	function automatic logic [31:0] lanes(input logic [1:0] pw);
		unique case (pw)
			emcs_pkg::PORT_W8: lanes = emcs_pkg::LANES_8;
			emcs_pkg::PORT_W16: lanes = emcs_pkg::LANES_16;
			default: lanes = emcs_pkg::LANES_32;
		endcase
	endfunction

	function automatic logic [4:0] shift(input logic [1:0] pw, input logic [1:0] beat);
		unique case (pw)
			emcs_pkg::PORT_W8: shift = {beat, 3'h0};
			emcs_pkg::PORT_W16: shift = {beat[0], 4'h0};
			default: shift = 5'h00;
		endcase
	endfunction

	always_comb begin
		logic [2:0] idx;
		logic any_hit;
		logic [1:0] epw;
		logic active;
		logic [4:0] sh;
		idx = 3'h0;
		any_hit = 1'b0;
		epw = emcs_pkg::PORT_W32;
		active = 1'b0;
		sh = 5'h00;
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		beat_nxt = beat_r;
		last_nxt = last_r;
		pw_nxt = pw_r;
		szw_nxt = szw_r;
		sel_nxt = sel_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		write_nxt = write_r;
		split_nxt = split_r;
		wait_nxt = wait_r;
		sec_nxt = sec_r;
		grant_nxt = grant_r;
		resp_nxt = '0;
		resp_nxt.rdata = resp_r.rdata;
		// Lowest numbered hit wins where regions overlap
		for (int i = emcs_pkg::NUM_CS - 1; i >= 0; i--) begin
			if (hit[i]) begin
				idx = 3'(i);
				any_hit = 1'b1;
			end
		end
		unique case (state_r)
			emcs_pkg::ST_IDLE: begin
				// Only SDR shares the whole bus with the SDRAM unit
				grant_nxt = sdram_ctrl_unit_req && !ddr_s2_r && !(req.valid && ready_r);
				if (req.valid && ready_r) begin
					if (!any_hit || blk[idx]) begin
						resp_nxt.valid = 1'b1;
						resp_nxt.error = 1'b1;
						resp_nxt.rdata = 32'h0000_0000;
					end else begin
						epw = cs_cfg[idx].port_w;
						// DDR leaves only sixteen lines, so wider ports run as 16 bits
						if (ddr_s2_r && epw != emcs_pkg::PORT_W8)
							epw = emcs_pkg::PORT_W16;
						pw_nxt = epw;
						szw_nxt = (req.size == emcs_pkg::SIZE_BYTE) ? emcs_pkg::PORT_W8 :
							(req.size == emcs_pkg::SIZE_HALF) ? emcs_pkg::PORT_W16 : emcs_pkg::PORT_W32;
						unique case (epw)
							emcs_pkg::PORT_W8: begin
								last_nxt = (req.size == emcs_pkg::SIZE_BYTE) ? emcs_pkg::LAST_BEAT_1 :
									(req.size == emcs_pkg::SIZE_HALF) ? emcs_pkg::LAST_BEAT_2 :
									emcs_pkg::LAST_BEAT_4;
							end
							emcs_pkg::PORT_W16: begin
								last_nxt = (req.size == emcs_pkg::SIZE_WORD) ? emcs_pkg::LAST_BEAT_2 :
									emcs_pkg::LAST_BEAT_1;
							end
							default: last_nxt = emcs_pkg::LAST_BEAT_1;
						endcase
						sel_nxt = emcs_pkg::CS_ONE_HOT << idx;
						addr_nxt = req.addr;
						wdata_nxt = req.wdata;
						rdata_nxt = 32'h0000_0000;
						write_nxt = req.write;
						split_nxt = cs_cfg[idx].split_strobes;
						wait_nxt = cs_cfg[idx].wait_st;
						sec_nxt = cs_cfg[idx].sec_wait;
						beat_nxt = 2'h0;
						state_nxt = emcs_pkg::ST_ADDR;
					end
				end
			end
			emcs_pkg::ST_ADDR: begin
				cnt_nxt = wait_r;
				state_nxt = emcs_pkg::ST_WAIT1;
			end
			emcs_pkg::ST_WAIT1: begin
				if (cnt_r == emcs_pkg::WAIT_ZERO) begin
					cnt_nxt = sec_r;
					state_nxt = emcs_pkg::ST_WAIT2;
				end else begin
					cnt_nxt = cnt_r - emcs_pkg::WAIT_ONE;
				end
			end
			emcs_pkg::ST_WAIT2: begin
				if (cnt_r == emcs_pkg::WAIT_ZERO)
					state_nxt = emcs_pkg::ST_DATA;
				else
					cnt_nxt = cnt_r - emcs_pkg::WAIT_ONE;
			end
			emcs_pkg::ST_DATA: begin
				sh = shift(pw_r, beat_r);
				if (!write_r)
					rdata_nxt = rdata_r | ((din_s2_r & lanes(pw_r)) << sh);
				if (beat_r == last_r) begin
					resp_nxt.valid = 1'b1;
					resp_nxt.rdata = write_r ? 32'h0000_0000 : rdata_nxt;
					state_nxt = emcs_pkg::ST_IDLE;
				end else begin
					beat_nxt = beat_r + 2'h1;
					state_nxt = emcs_pkg::ST_ADDR;
				end
			end
			default: state_nxt = emcs_pkg::ST_IDLE;
		endcase

		// Pin values follow the next state so each pin comes from a flop
		active = (state_nxt != emcs_pkg::ST_IDLE);
		sh = shift(pw_nxt, beat_nxt);
		cs_n_nxt = active ? ~sel_nxt : emcs_pkg::CS_ALL_OFF;
		avn_nxt = (state_nxt != emcs_pkg::ST_ADDR);
		ren_nxt = !(active && state_nxt != emcs_pkg::ST_ADDR && split_nxt && !write_nxt);
		wen_nxt = !(active && state_nxt != emcs_pkg::ST_ADDR && split_nxt && write_nxt);
		rw_nxt = !(active && write_nxt);
		eaddr_nxt = active ? addr_nxt + {27'h0, sh} / 32'h8 : eaddr_r;
		dout_nxt = active ? wdata_nxt >> sh : dout_r;
		doe_nxt = (active && write_nxt) ? lanes(pw_nxt) & lanes(szw_nxt) : 32'h0000_0000;
		if (ddr_s2_r)
			doe_nxt = doe_nxt & emcs_pkg::DDR_OWN_LANES;
		ready_nxt = !active && !grant_nxt && !srst;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= emcs_pkg::ST_IDLE;
			cnt_r <= 4'h0;
			beat_r <= 2'h0;
			last_r <= 2'h0;
			pw_r <= emcs_pkg::PORT_W32;
			szw_r <= emcs_pkg::PORT_W32;
			sel_r <= 6'h00;
			addr_r <= 32'h0000_0000;
			wdata_r <= 32'h0000_0000;
			rdata_r <= 32'h0000_0000;
			write_r <= 1'b0;
			split_r <= 1'b0;
			wait_r <= 4'h0;
			sec_r <= 4'h0;
			grant_r <= 1'b0;
			ready_r <= 1'b0;
			resp_r <= '0;
			cs_n_r <= emcs_pkg::CS_ALL_OFF;
			avn_r <= 1'b1;
			ren_r <= 1'b1;
			wen_r <= 1'b1;
			rw_r <= 1'b1;
			eaddr_r <= 32'h0000_0000;
			dout_r <= 32'h0000_0000;
			doe_r <= 32'h0000_0000;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			beat_r <= beat_nxt;
			last_r <= last_nxt;
			pw_r <= pw_nxt;
			szw_r <= szw_nxt;
			sel_r <= sel_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			write_r <= write_nxt;
			split_r <= split_nxt;
			wait_r <= wait_nxt;
			sec_r <= sec_nxt;
			grant_r <= grant_nxt;
			ready_r <= ready_nxt;
			resp_r <= resp_nxt;
			cs_n_r <= cs_n_nxt;
			avn_r <= avn_nxt;
			ren_r <= ren_nxt;
			wen_r <= wen_nxt;
			rw_r <= rw_nxt;
			eaddr_r <= eaddr_nxt;
			dout_r <= dout_nxt;
			doe_r <= doe_nxt;
		end
	end

	assign req_ready = ready_r;
	assign resp = resp_r;
	assign sdram_ctrl_unit_grant = grant_r;
	assign cs_n = cs_n_r;
	assign address_valid_n = avn_r;
	assign read_en_n = ren_r;
	assign write_en_n = wen_r;
	assign rd_wr_n = rw_r;
	assign ext_addr = eaddr_r;
	assign ext_data_out = dout_r;
	assign ext_data_oe = doe_r;
endmodule // emcs_bus

`default_nettype wire

//--- hdl/emcs_cs_match.sv
// Address and protection decode of one chip select.
// Purely combinational; the caller registers whatever it keeps.
`default_nettype none

module emcs_cs_match (
	// Setup of this chip select
	input wire emcs_pkg::emcs_cs_cfg_type cfg,
	// Access being decoded
	input wire logic [31:0] addr,
	input wire logic write,
	input wire logic user,
	// Decode result
	output logic hit,
	output logic blocked
);
	// Base is assumed aligned to the block size, so a mask compare suffices
	assign hit = cfg.enable && (((addr[31:16] ^ cfg.base) & ~cfg.mask) == 16'h0000);
	assign blocked = (cfg.user_block && user) || (cfg.write_block && write);
endmodule // emcs_cs_match

`default_nettype wire

//--- tb/emcs_bus_assertions.sv
// Port checker of the chip-select bus.
// Assumes bench regions never overlap, so chip select 4 alone decodes its base,
// and that only chip select 0 runs without split strobes.
`default_nettype none

module emcs_bus_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Setup and internal side
	input wire emcs_pkg::emcs_cs_cfg_type [emcs_pkg::NUM_CS-1:0] cs_cfg,
	input wire logic dram_type_select,
	input wire emcs_pkg::emcs_req_type req,
	input wire logic req_ready,
	input wire emcs_pkg::emcs_resp_type resp,
	input wire logic sdram_ctrl_unit_grant,
	// External side
	input wire logic [emcs_pkg::NUM_CS-1:0] cs_n,
	input wire logic address_valid_n,
	input wire logic write_en_n,
	input wire logic read_en_n,
	input wire logic rd_wr_n,
	input wire logic [31:0] ext_addr,
	input wire logic [31:0] ext_data_oe
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	AST_DDR_LANES: assert property (dram_type_select [*4] |-> ext_data_oe[31:16] == 16'h0000)
		else $error("upper lanes driven in DDR");
	AST_GRANT_QUIET: assert property (sdram_ctrl_unit_grant |-> ext_data_oe == 32'h0000_0000)
		else $error("data driven while granted");
	AST_ONE_SELECT: assert property ($countones(~cs_n) <= 1)
		else $error("two chip selects");
	AST_BUSY: assert property (!(&cs_n) |-> !req_ready && !sdram_ctrl_unit_grant)
		else $error("ready or grant in access");
	AST_STROBE: assert property (!address_valid_n |-> !(&cs_n) ##1 address_valid_n && !(&cs_n))
		else $error("bad address strobe");
	AST_WR_STROBE: assert property (!write_en_n |-> !rd_wr_n && read_en_n && !(&cs_n))
		else $error("bad write strobe");
	AST_RD_SPLIT: assert property (!(&cs_n) && cs_n[0] && address_valid_n
		|-> read_en_n != rd_wr_n && write_en_n == rd_wr_n)
		else $error("split strobes wrong");
	AST_NO_SPLIT: assert property (
		!cs_n[0] && !cs_cfg[0].split_strobes |-> read_en_n && write_en_n)
		else $error("strobes without split");
	AST_WR_BLOCK: assert property (
		req.valid && req_ready && req.write && cs_cfg[4].write_block
		&& req.addr[31:16] == cs_cfg[4].base |=> resp.valid && resp.error)
		else $error("write not refused");
	AST_REGION0: assert property (
		!cs_n[0] |-> ((ext_addr[31:16] ^ cs_cfg[0].base) & ~cs_cfg[0].mask) == 16'h0000)
		else $error("select outside region");
	AST_REFUSED: assert property (resp.valid && resp.error |-> $past(&cs_n) && $past(write_en_n))
		else $error("refused access reached pins");
endmodule // emcs_bus_chk

bind emcs_bus emcs_bus_chk u_chk (.clk, .srst, .cs_cfg, .dram_type_select, .req, .req_ready,
	.resp, .sdram_ctrl_unit_grant, .cs_n, .address_valid_n, .write_en_n, .read_en_n, .rd_wr_n,
	.ext_addr, .ext_data_oe);

`default_nettype wire

//--- tb/emcs_mem_model.sv
// External memory model: 64 bytes seen by every region.
// Assumes lane k of a beat holds the byte at the beat address plus k.
`default_nettype none

module emcs_mem_model (
	// Clock and pace
	input wire logic clk,
	input wire logic slow,
	// Pins
	input wire logic [5:0] cs_n,
	input wire logic [31:0] ext_addr,
	input wire logic rd_wr_n,
	input wire logic [31:0] ext_data_out,
	input wire logic [31:0] ext_data_oe,
	output logic [31:0] ext_data_in
);
	logic [7:0] mem [64];
	logic [31:0] last_r = 32'h0000_0000;
	logic [31:0] prev_r = 32'h0000_0000;
	int cnt_r = 0;
	logic [5:0] a;
	assign a = ext_addr[5:0];
	initial for (int i = 0; i < 64; i++) mem[i] = 8'(i);
	always @(posedge clk) begin
		for (int k = 0; k < 4; k++) begin
			if (!(&cs_n) && !rd_wr_n && ext_data_oe[8*k]) mem[6'(a + 6'(k))] <= ext_data_out[8*k +: 8];
		end
		cnt_r <= (&cs_n || ext_addr != prev_r) ? 0 : cnt_r + 1;
		prev_r <= ext_addr;
		last_r <= ext_data_in;
	end
	// Stale or idle: inverse of last value, so old data never passes for new
	always_comb begin
		if (!(&cs_n) && rd_wr_n && cnt_r >= (slow ? 2 : 0))
			ext_data_in = {mem[6'(a + 6'h3)], mem[6'(a + 6'h2)], mem[6'(a + 6'h1)], mem[a]};
		else
			ext_data_in = ~last_r;
	end
endmodule // emcs_mem_model

`default_nettype wire

//--- tb/tb.sv
// Bench of the chip-select bus: corner and random accesses, bus share, DDR mode.
// Assumes package, design, checker and memory model compiled first.
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic dram_type_select = 1'b0;
	logic sdram_ctrl_unit_req = 1'b0;
	logic slow = 1'b0;
	logic req_ready, sdram_ctrl_unit_grant, address_valid_n, read_en_n, write_en_n, rd_wr_n;
	logic [5:0] cs_n;
	logic [31:0] ext_addr, ext_data_in, ext_data_out, ext_data_oe;
	emcs_pkg::emcs_cs_cfg_type [emcs_pkg::NUM_CS-1:0] cs_cfg;
	emcs_pkg::emcs_req_type req = '0;
	emcs_pkg::emcs_resp_type resp;
	logic [7:0] ref_m [64];
	int bad_count = 0;
	int num_checks = 0;
	int avn_cnt = 0;
	always #50 clk = ~clk;
	always @(posedge clk) if (!address_valid_n) avn_cnt++;
	emcs_bus u_dut (.clk, .srst, .cs_cfg, .dram_type_select, .req, .req_ready, .resp,
		.sdram_ctrl_unit_req, .sdram_ctrl_unit_grant, .cs_n, .address_valid_n, .read_en_n,
		.write_en_n, .rd_wr_n, .ext_addr, .ext_data_in, .ext_data_out, .ext_data_oe);
	emcs_mem_model u_mem (.clk, .slow, .cs_n, .ext_addr, .rd_wr_n, .ext_data_out, .ext_data_oe,
		.ext_data_in);

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	function automatic emcs_pkg::emcs_cs_cfg_type mk(input int i);
		emcs_pkg::emcs_cs_cfg_type c;
		c = '0;
		c.enable = i != 5;
		c.base = 16'h1000 * 16'(i + 1);
		c.port_w = i == 1 ? emcs_pkg::PORT_W8 : i == 2 ? emcs_pkg::PORT_W16 : emcs_pkg::PORT_W32;
		c.wait_st = i == 2 ? 4'h2 : 4'(i == 1);
		c.sec_wait = i == 1 ? 4'h2 : 4'h0;
		c.user_block = i == 3;
		c.write_block = i == 4;
		c.split_strobes = i != 0;
		return c;
	endfunction

	function automatic int beats(input int cs, input logic [1:0] sz);
		int pw;
		pw = cs == 1 ? 1 : (cs == 2 || dram_type_select) ? 2 : 4;
		return ((1 << sz) > pw) ? (1 << sz) / pw : 1;
	endfunction

	task automatic acc(input int cs, input logic [5:0] off, input logic [1:0] sz,
		input logic wr, input logic usr, input logic [31:0] wd);
		int k;
		int n;
		int a0;
		logic no;
		logic [31:0] exp;
		logic [31:0] m;
		no = cs == 5 || (cs == 3 && usr) || (cs == 4 && wr);
		n = no ? 1 : 1 + beats(cs, sz) * (4 + int'(cs_cfg[cs].wait_st)
			+ int'(cs_cfg[cs].sec_wait));
		off = off & ~6'((1 << sz) - 1);
		exp = '0;
		m = '0;
		for (k = 0; k < (1 << sz); k++) begin
			if (wr && !no) ref_m[off + 6'(k)] = wd[8*k +: 8];
			exp[8*k +: 8] = no ? 8'h00 : ref_m[off + 6'(k)];
			m[8*k +: 8] = 8'hff;
		end
		@(posedge clk);
		a0 = avn_cnt;
		slow <= cs == 1;
		req <= '{1'b1, {cs_cfg[cs].base, 10'h000, off}, wd, sz, wr, usr};
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (req_ready !== 1'b1 && k < 200);
		req <= '0;
		if (req_ready !== 1'b1) k = 300;
		else for (k = 0; k < 300 && resp.valid !== 1'b1; k++) @(negedge clk);
		if (k == 300) begin
			bad_count++;
			$display("mismatch at %0t: no answer", $time);
			wrap_up();
		end else begin
			chk(k, n, "latency");
			chk(32'(resp.error), 32'(no), "error");
			if (!wr) chk(resp.rdata & m, exp, "read data");
			chk(avn_cnt - a0, no ? 0 : beats(cs, sz), "strobes");
		end
	endtask

	initial begin
		for (int i = 0; i < 6; i++) cs_cfg[i] = mk(i);
		for (int i = 0; i < 64; i++) ref_m[i] = 8'(i);
		void'($urandom(32'h9687));
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk({26'h0, cs_n}, 32'h0000_003f, "idle selects");
		acc(3, 6'h00, 2'h2, '0, '1, '0);
		acc(3, 6'h04, 2'h2, '1, '0, 32'hcafe_0123);
		acc(4, 6'h08, 2'h2, '1, '0, 32'h1234_5678);
		acc(4, 6'h08, 2'h2, '0, '1, '0);
		acc(5, 6'h00, 2'h0, '0, '0, '0);
		acc(1, 6'h0c, 2'h2, '1, '0, 32'ha5a5_5a5a);
		acc(1, 6'h0c, 2'h2, '0, '0, '0);
		for (int i = 0; i < 40; i++) acc($urandom_range(5), 6'($urandom), 2'($urandom_range(2)),
			1'($urandom), 1'($urandom), $urandom);
		@(posedge clk);
		sdram_ctrl_unit_req <= 1'b1;
		repeat (3) @(posedge clk);
		chk(32'({sdram_ctrl_unit_grant, req_ready}), 32'h0000_0002, "share");
		sdram_ctrl_unit_req <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(sdram_ctrl_unit_grant), 32'h0000_0000, "release");
		dram_type_select <= 1'b1;
		repeat (4) @(posedge clk);
		sdram_ctrl_unit_req <= 1'b1;
		repeat (3) @(posedge clk);
		chk(32'(sdram_ctrl_unit_grant), 32'h0000_0000, "ddr grant");
		for (int i = 0; i < 20; i++) acc($urandom_range(5), 6'($urandom), 2'($urandom_range(2)),
			1'($urandom), 1'($urandom), $urandom);
		wrap_up();
	end
endmodule // tb

`default_nettype wire
